// >>> dv/eeprom_write_lock_and_settings_transfer_bench.sv
/* Bench for the settings memory controller: table of settings accesses,
   then lock, store, download and page cases. Assumes the host model. */
`timescale 1ns/10ps
`include "nvm_ctrl_params.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end
module eeprom_write_lock_and_settings_transfer_bench;
  import nvm_ctrl_pkg::*;
  typedef struct {logic [7:0] adr; logic [7:0] wd; logic [7:0] exp;} row_t;
  logic clk;
  logic nrst;
  wb_req_s wbReq;
  wb_rsp_s wbRsp;
  cfg_t cfgOut;
  logic crcFault;
  logic unlocked;
  int fails;
  int compares;
  logic [31:0] r;
  cfg_t cfgExp = {8'h11, 8'h7e, 8'h3c, 8'h00, 8'h80, 8'hff, 8'h01, 8'h5a};
  row_t rows[9] = '{'{8'h20, 8'h5a, 8'h5a}, '{8'h24, 8'h01, 8'h01}, '{8'h28, 8'hff, 8'hff},
    '{8'h2c, 8'h80, 8'h80}, '{8'h30, 8'h00, 8'h00}, '{8'h34, 8'h3c, 8'h3c},
    '{8'h38, 8'h7e, 8'h7e}, '{8'h3c, 8'h11, 8'h11}, '{8'h18, 8'hff, 8'h00}};
  nvm_ctrl #(.ERASE_CYC(600)) i_nvm_ctrl (.clk(clk), .nrst(nrst), .wbReq(wbReq),
    .wbRsp(wbRsp), .cfgOut(cfgOut), .crcFault(crcFault), .unlocked(unlocked));
  wb_host i_wb_host (.clk(clk), .wbReq(wbReq), .wbRsp(wbRsp));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // A transfer that never gets its ack counts as a mismatch
  task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d);
    bit late;
    i_wb_host.xfer(w, a, d, r, late);
    if (late) begin
      fails++;
      $display("BAD %0t no answer", $time);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    access(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    access(1'b0, a, 32'h0);
  endtask
  task automatic cmd(input logic [7:0] c, input logic [7:0] a0, input logic [7:0] a1);
    wr(`OFS_CMD, {8'h00, a1, a0, c});
  endtask
  // Polls busy rather than counting, as the host must hold off until done
  task automatic idle();
    repeat (400) begin
      rd(`OFS_STATUS);
      if (r[`STAT_BUSY] === 1'b0) return;
    end
    fails++;
    $display("BAD %0t busy stuck", $time);
  endtask
  task automatic summarize();
    $display("fails %0d compares %0d", fails, compares);
    if (fails == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #500000;
    fails++;
    summarize();
  end
  initial begin
    nrst = 1'b0;
    fails = 0;
    compares = 0;
    repeat (10) @(posedge clk);
    `CHK(unlocked, 1'b0)
    nrst <= 1'b1;
    repeat (40) @(posedge clk);
    foreach (rows[i]) begin
      wr(rows[i].adr, {24'h0, rows[i].wd});
      rd(rows[i].adr);
      `CHK(r[7:0], rows[i].exp)
    end
    `CHK(cfgOut, cfgExp)
    $display("test table done");
    cmd(`CMD_PAGE_ERASE, 8'h04, 8'h00);
    rd(`OFS_STATUS);
    `CHK(r[`STAT_FAIL], 1'b1)
    cmd(`CMD_STORE_USER, 8'h00, 8'h00);
    rd(`OFS_STATUS);
    `CHK(r[`STAT_FAIL], 1'b1)
    cmd(`CMD_PASSWORD, `PW_FACTORY, 8'h00);
    cmd(`CMD_PASSWORD, `PW_FACTORY, 8'h00);
    `CHK(unlocked, 1'b1)
    rd(`OFS_STATUS);
    `CHK(r[`STAT_UNLOCKED], 1'b1)
    cmd(8'hf1, 8'h00, 8'h00);
    rd(`OFS_STATUS);
    `CHK(r[`STAT_FAIL], 1'b1)
    $display("test lock done");
    cmd(`CMD_STORE_USER, 8'h00, 8'h00);
    idle();
    wr(8'h20, 32'h0);
    cmd(`CMD_RESTORE_USER, 8'h00, 8'h00);
    idle();
    `CHK(cfgOut, cfgExp)
    `CHK(crcFault, 1'b0)
    rd(`OFS_CHKSUM);
    `CHK(r[7:0], 8'h1a)
    cmd(8'hb1, 8'h01, 8'h00);
    rd(`OFS_STATUS);
    `CHK(r[`STAT_FAIL], 1'b1)
    cmd(`CMD_ADDR_OFFSET, 8'h00, 8'h08);
    cmd(8'hb1, 8'h00, 8'h00);
    rd(`OFS_RDATA);
    `CHK(r[7:0], 8'h1a)
    $display("test store done");
    cmd(`CMD_PAGE_ERASE, 8'h04, 8'h00);
    idle();
    cmd(8'hb4, 8'h01, 8'h01);
    rd(`OFS_STATUS);
    `CHK(r[`STAT_FAIL], 1'b1)
    cmd(`CMD_ADDR_OFFSET, 8'h01, 8'h05);
    rd(`OFS_OFFSET);
    `CHK(r[8:0], 9'h105)
    cmd(8'hb4, 8'h00, 8'h01);
    rd(`OFS_STATUS);
    `CHK(r[`STAT_FAIL], 1'b0)
    wr(`OFS_WDATA, 32'ha5);
    wr(`OFS_WDATA, 32'h3c);
    cmd(`CMD_ADDR_OFFSET, 8'h01, 8'h05);
    cmd(8'hb4, 8'h01, 8'h00);
    wr(`OFS_WDATA, 32'h00);
    rd(`OFS_STATUS);
    `CHK(r[`STAT_FAIL], 1'b1)
    cmd(`CMD_ADDR_OFFSET, 8'h01, 8'h05);
    cmd(8'hb4, 8'h00, 8'h00);
    rd(`OFS_RDATA);
    `CHK(r[7:0], 8'ha5)
    rd(`OFS_RDATA);
    `CHK(r[7:0], 8'h3c)
    rd(`OFS_RDATA);
    `CHK(r[7:0], `ERASED_BYTE)
    $display("test page done");
    cmd(`CMD_PASSWORD, 8'h00, 8'h00);
    `CHK(unlocked, 1'b0)
    cmd(8'hb4, 8'h01, 8'h00);
    wr(`OFS_WDATA, 32'h00);
    rd(`OFS_STATUS);
    `CHK(r[`STAT_FAIL], 1'b1)
    cmd(`CMD_ADDR_OFFSET, 8'h00, 8'h00);
    cmd(8'hb1, 8'h00, 8'h00);
    rd(`OFS_RDATA);
    `CHK(r[7:0], 8'hff)
    cmd(`CMD_PASSWORD, `PW_FACTORY, 8'h00);
    cmd(`CMD_PASSWORD, 8'hc3, 8'h00);
    cmd(`CMD_PASSWORD, 8'hc3, 8'h00);
    cmd(`CMD_PASSWORD, 8'hc3, 8'h00);
    `CHK(unlocked, 1'b1)
    cmd(`CMD_RESTORE_DEFAULT, 8'h00, 8'h00);
    idle();
    cmd(`CMD_PASSWORD, 8'h00, 8'h00);
    cmd(`CMD_PASSWORD, `PW_FACTORY, 8'h00);
    cmd(`CMD_PASSWORD, `PW_FACTORY, 8'h00);
    `CHK(unlocked, 1'b1)
    $display("test password done");
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    `CHK(unlocked, 1'b0)
    rd(`OFS_STATUS);
    `CHK(cfgOut, cfgExp)
    `CHK(crcFault, 1'b0)
    $display("test reset done");
    summarize();
  end
endmodule

// >>> dv/nvm_ctrl_monitor.sv
/* Assertions on the controller ports.
   Assumes the bench master holds each request until ack. */
`timescale 1ns/10ps
`include "nvm_ctrl_params.svh"
module nvm_ctrl_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Bus
  input nvm_ctrl_pkg::wb_req_s wbReq,
  input nvm_ctrl_pkg::wb_rsp_s wbRsp,
  // Settings and flags
  input nvm_ctrl_pkg::cfg_t cfgOut,
  input wire logic crcFault,
  input wire logic unlocked
);
  import nvm_ctrl_pkg::*;
  logic [7:0] loadAge_q;
  logic [7:0] loadAge_d;
  logic pwReq;
  logic cfgReq;
  logic loadCmd;
  assign pwReq = wbReq.cyc && wbReq.stb && wbReq.we && wbReq.adr == `OFS_CMD
      && wbReq.dat[7:0] == `CMD_PASSWORD;
  assign cfgReq = wbRsp.ack && wbReq.we && wbReq.adr[5];
  assign loadCmd = wbRsp.ack && wbReq.we && wbReq.adr == `OFS_CMD
      && (wbReq.dat[7:0] == `CMD_RESTORE_USER || wbReq.dat[7:0] == `CMD_RESTORE_DEFAULT);
  // Saturating age since the last download started
  always_comb begin
    loadAge_d = (loadAge_q == 8'hff) ? loadAge_q : loadAge_q + 8'h01;
    if (loadCmd) begin
      loadAge_d = 8'h00;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      loadAge_q <= 8'h00;
    end else begin
      loadAge_q <= loadAge_d;
    end
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);
  sequence reqStart;
    wbReq.cyc && wbReq.stb && !$past(wbReq.cyc && wbReq.stb);
  endsequence
  sequence ackSeen;
    ##[1:700] wbRsp.ack;
  endsequence
  bus_answer_a: assert property (reqStart |-> ackSeen) else $error("request unanswered");
  ack_pulse_a: assert property (wbRsp.ack |=> !wbRsp.ack) else $error("ack too long");
  ack_held_a: assert property (wbRsp.ack |-> wbReq.cyc && wbReq.stb) else $error("stray ack");
  write_zero_a: assert property (wbRsp.ack && wbReq.we |-> wbRsp.dat == 32'h0)
    else $error("write returned data");
  wdata_lat_a: assert property (wbRsp.ack && wbReq.we && wbReq.adr == `OFS_WDATA
      |-> $past(wbReq.cyc && wbReq.stb, 3)) else $error("data write acked early");
  reset_lock_a: assert property (nrst && !$past(nrst) |-> !unlocked)
    else $error("unlocked after reset");
  unlock_cause_a: assert property ($rose(unlocked) |-> pwReq || $past(pwReq))
    else $error("unlock without password");
  lock_cause_a: assert property ($fell(unlocked) |-> pwReq || $past(pwReq))
    else $error("lock without password");
  crc_change_a: assert property ($changed(crcFault) |-> loadAge_q < 8'h28)
    else $error("checksum flag moved outside download");
  cfg_change_a: assert property ($changed(cfgOut) |-> loadAge_q < 8'h28
      || cfgReq || $past(cfgReq)) else $error("settings moved without cause");
endmodule
bind nvm_ctrl nvm_ctrl_monitor i_nvm_ctrl_monitor (.clk(clk), .nrst(nrst), .wbReq(wbReq),
  .wbRsp(wbRsp), .cfgOut(cfgOut), .crcFault(crcFault), .unlocked(unlocked));

// >>> dv/wb_host.sv
/* Host-side model: issues classic single Wishbone cycles on request.
   Assumes the slave answers with ack while the request is held. */
`timescale 1ns/10ps
module wb_host (
  // Clock
  input wire logic clk,
  // Bus
  output nvm_ctrl_pkg::wb_req_s wbReq,
  input nvm_ctrl_pkg::wb_rsp_s wbRsp
);
  import nvm_ctrl_pkg::*;
  initial wbReq = '0;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output bit late);
    int n;
    n = 0;
    @(posedge clk);
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: d};
    do begin
      @(posedge clk);
      n++;
    end while (wbRsp.ack !== 1'b1 && n < 2000);
    q = wbRsp.dat;
    late = (wbRsp.ack !== 1'b1);
    // Released lines carry inverted leftovers so stale values never pass
    wbReq <= '{cyc: 1'b0, stb: 1'b0, we: ~w, adr: ~a, sel: 4'h0, dat: ~d};
  endtask
endmodule

// >>> hw/nvm_array.sv
/*
  Byte-wide main block storage: sixteen pages of 512 bytes, one port.
  Assumes the controller sequences erase and programming; read data is
  registered and valid one cycle after the address.
*/
`timescale 1ns/10ps

module nvm_array (
  // Clock
  input wire logic clk,
  // Access port
  input wire logic we,
  input wire logic [12:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);

  logic [7:0] mem [0:8191];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule

// >>> hw/nvm_ctrl.sv
/*
  Settings memory controller: password lock, page programming, page erase,
  settings download and store with ones-count checksum, behind a classic
  Wishbone slave. Assumes a 100 MHz clock and a single-cycle bus master
  that holds its request until ack.
*/
`timescale 1ns/10ps

`include "nvm_ctrl_params.svh"

// Overview of operation
// [R1] No software path writes the fault record block.
// [R2] Page data writes to pages 0 or 1 fail and store nothing.
// [R3] Software should keep off pages 2 and 3, using pages 4 to 15.
// [R4] Software unlocks with the password before writing general pages.
// [R5] Page data commands 0xB0-0xBF program bytes in order.
// [R6] Offset command sets the byte position for the next page transfer.
// [R7] One block write carries at most 256 bytes.
// [R8] Locked after reset; writes and erases blocked while locked.
// [R9] While locked, reads of pages 0 and 1 return invalid data.
// [R10] Two consecutive correct passwords unlock and set status bit 4.
// [R11] A wrong password byte locks and clears the unlocked flag.
// [R12] Correct password then a new byte adopts the new password.
// [R13] After reset the user page loads into the settings registers.
// [R14] Restore-user reloads settings from the user page.
// [R15] Restore-default loads the default page and resets the password.
// [R16] Nothing stores settings into the default page.
// [R17] Store-user saves settings to page 1, only when unlocked.
// [R18] Store-user erases page 1 first; stays busy for 35 ms.
// [R19] Store appends the ones count of the saved settings.
// [R20] Download counts ones and flags a mismatch in status bit 1.
// [R21] Checksum register returns the count of the latest download.
// [R22] The checksum counter is eight bits and wraps.
// [R23] Page erase erases one page 4-15 and stays busy 35 ms.
// [R24] Erase sets bytes high; only erased bytes are programmed.
// [R25] Locked writes or erases are refused and flagged as failed.
module nvm_ctrl #(
  parameter int unsigned ERASE_CYC = `ERASE_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Wishbone slave
  input nvm_ctrl_pkg::wb_req_s wbReq,
  output nvm_ctrl_pkg::wb_rsp_s wbRsp,
  // Settings registers and status flags as seen by the rest of the chip
  output nvm_ctrl_pkg::cfg_t cfgOut,
  output logic crcFault,
  output logic unlocked
);
  import nvm_ctrl_pkg::*;

  st_s st_q;
  st_s st_d;
  logic [7:0] memRd;

  nvm_array u_array (
    .clk(clk),
    .we(st_q.memWe),
    .addr(st_q.memAddr),
    .wdata(st_q.memWd),
    .rdata(memRd)
  );

  function automatic logic [7:0] ones(input logic [7:0] v);
    logic [7:0] n;
    n = 8'h00;
    for (int i = 0; i < 8; i++) begin
      n = n + {7'h00, v[i]};
    end
    return n;
  endfunction

  logic req;
  logic busy;
  logic [7:0] code;
  logic [7:0] arg0;
  logic [7:0] arg1;
  logic [8:0] blkCnt;
  logic [3:0] cfgIdx;
  logic cfgHit;
  logic [7:0] srcByte;
  logic [31:0] regWord;

  assign req = wbReq.cyc & wbReq.stb & ~st_q.rsp.ack;
  assign busy = st_q.timer != 22'h0;
  assign code = wbReq.dat[7:0];
  assign arg0 = wbReq.dat[15:8];
  assign arg1 = wbReq.dat[23:16];
  assign blkCnt = wbReq.dat[16:8];
  assign cfgIdx = wbReq.adr[5:2];
  // Eight settings words from 0x20 up; masking keeps the compare at the bus width
  assign cfgHit = (wbReq.adr & 8'he0) == `OFS_CFG;
  assign srcByte = (st_q.idx < 9'(`NCFG)) ? st_q.cfg[st_q.idx[2:0]] : st_q.acc;

  // Registers that answer in one cycle; unmapped offsets read zero
  always_comb begin
    regWord = 32'h0;
    if (wbReq.adr == `OFS_STATUS) begin
      regWord[`STAT_BUSY] = busy;
      regWord[`STAT_CRC_FAULT] = st_q.crcFault; // see [R20]
      regWord[`STAT_FAIL] = st_q.fail;
      regWord[`STAT_UNLOCKED] = st_q.unlocked; // see [R10]
    end else if (wbReq.adr == `OFS_CHKSUM) begin
      regWord = {24'h0, st_q.chk}; // see [R21]
    end else if (wbReq.adr == `OFS_OFFSET) begin
      regWord = {23'h0, st_q.offset};
    end else if (cfgHit) begin
      regWord = {24'h0, st_q.cfg[cfgIdx[2:0]]};
    end
  end

  always_comb begin
    st_d = st_q;
    st_d.rsp.ack = 1'b0;
    st_d.memWe = 1'b0;
    // The timer runs on after the page walk, so busy covers the whole span
    if (busy) begin
      st_d.timer = st_q.timer - 22'h1;
    end
    unique case (st_q.fsm)
      S_IDLE: begin
        if (req) begin
          st_d.rsp.ack = 1'b1;
          st_d.rsp.dat = 32'h0;
          if (wbReq.we && wbReq.sel[0]) begin
            if (wbReq.adr == `OFS_CMD) begin
              st_d.armed = 1'b0;
              if (busy) begin
                st_d.fail = 1'b1;
              end else if (code[7:4] == `CMD_PAGE_DATA) begin
                st_d.page = code[3:0];
                st_d.count = 9'h0;
                // Default and user pages are never programmed directly: see [R2] [R16]
                if (code[3:0] < `PAGE_FIRST_FREE && code[3:1] == 3'h0 && blkCnt != 9'h0) begin
                  st_d.fail = 1'b1;
                end else if (blkCnt > `MAX_BLOCK) begin
                  st_d.fail = 1'b1; // see [R7]
                end else begin
                  st_d.count = blkCnt; // see [R5]
                  st_d.fail = 1'b0;
                end
              end else if (code == `CMD_ADDR_OFFSET) begin
                st_d.offset = {arg0[0], arg1}; // see [R6]
                st_d.fail = 1'b0;
              end else if (code == `CMD_PAGE_ERASE) begin
                // Only general pages, only unlocked: see [R23] [R25] [R8]
                if (!st_q.unlocked || arg0 > 8'h0f || arg0[3:0] < `PAGE_FIRST_FREE) begin
                  st_d.fail = 1'b1;
                end else begin
                  st_d.fail = 1'b0;
                  st_d.page = arg0[3:0];
                  st_d.storing = 1'b0;
                  st_d.idx = 9'h0;
                  st_d.timer = 22'(ERASE_CYC); // see [R23]
                  st_d.fsm = S_ERASE;
                end
              end else if (code == `CMD_PASSWORD) begin
                st_d.fail = 1'b0;
                if (st_q.armed && arg0 == st_q.pw) begin
                  st_d.unlocked = 1'b1; // see [R10]
                end else if (st_q.armed) begin
                  // Second byte differs from the password: it becomes the password
                  st_d.pw = arg0; // see [R12]
                  st_d.unlocked = 1'b0;
                end else if (arg0 == st_q.pw) begin
                  st_d.armed = 1'b1; // see [R10] [R12]
                end else begin
                  st_d.unlocked = 1'b0; // see [R11]
                end
              end else if (code == `CMD_STORE_USER) begin
                if (!st_q.unlocked) begin
                  st_d.fail = 1'b1; // see [R17]
                end else begin
                  // Erase first, then program the image: see [R18]
                  st_d.fail = 1'b0;
                  st_d.page = `PAGE_USER;
                  st_d.storing = 1'b1;
                  st_d.idx = 9'h0;
                  st_d.timer = 22'(ERASE_CYC);
                  st_d.fsm = S_ERASE;
                end
              end else if (code == `CMD_RESTORE_USER || code == `CMD_RESTORE_DEFAULT) begin
                st_d.fail = 1'b0;
                if (code == `CMD_RESTORE_DEFAULT) begin
                  st_d.pw = `PW_FACTORY; // see [R15]
                end
                st_d.page = (code == `CMD_RESTORE_USER) ? `PAGE_USER : `PAGE_DEFAULT; // see [R14]
                st_d.memAddr = {st_d.page, 9'h0};
                st_d.idx = 9'h0;
                st_d.ph = 1'b0;
                st_d.acc = 8'h0;
                st_d.fsm = S_LOAD;
              end else begin
                // Unknown codes are refused; no code reaches the fault record block
                st_d.fail = 1'b1; // see [R1]
              end
            end else if (wbReq.adr == `OFS_WDATA) begin
              // Locked, exhausted or busy: refuse and keep memory intact
              if (!st_q.unlocked || st_q.count == 9'h0 || busy) begin
                st_d.fail = 1'b1; // see [R25] [R8] [R4]
              end else begin
                st_d.rsp.ack = 1'b0;
                st_d.memAddr = {st_q.page, st_q.offset};
                st_d.ph = 1'b0;
                st_d.fsm = S_PROG;
              end
            end else if (cfgHit) begin
              st_d.cfg[cfgIdx[2:0]] = wbReq.dat[7:0];
            end
          end else if (!wbReq.we) begin
            if (wbReq.adr == `OFS_RDATA) begin
              if (!st_q.unlocked && st_q.page[3:1] == 3'h0) begin
                st_d.rsp.dat = {24'h0, `ERASED_BYTE}; // see [R9]
                st_d.fail = 1'b1;
              end else begin
                st_d.rsp.ack = 1'b0;
                st_d.memAddr = {st_q.page, st_q.offset};
                st_d.ph = 1'b0;
                st_d.fsm = S_MEMRD;
              end
            end else begin
              st_d.rsp.dat = regWord;
            end
          end
        end
      end

      // Read the byte first: programming can only pull bits low
      S_PROG: begin
        st_d.ph = 1'b1;
        if (st_q.ph) begin
          // Bytes already pulled low since the last erase are not reprogrammed
          if (memRd == `ERASED_BYTE) begin
            st_d.memWe = 1'b1; // see [R24] [R5]
            st_d.memWd = wbReq.dat[7:0];
          end else begin
            st_d.fail = 1'b1; // see [R24]
          end
          st_d.offset = st_q.offset + 9'h1;
          st_d.count = st_q.count - 9'h1;
          st_d.rsp.ack = 1'b1;
          st_d.rsp.dat = 32'h0;
          st_d.fsm = S_IDLE;
        end
      end

      // Address and array read data are both registered, so the answer waits two extra cycles
      S_MEMRD: begin
        st_d.ph = 1'b1;
        if (st_q.ph) begin
          st_d.rsp.dat = {24'h0, memRd};
          st_d.offset = st_q.offset + 9'h1;
          st_d.rsp.ack = 1'b1;
          st_d.fsm = S_IDLE;
        end
      end

      // One byte per cycle across the whole page; bus requests stall meanwhile
      S_ERASE: begin
        st_d.memWe = 1'b1; // see [R24]
        st_d.memWd = `ERASED_BYTE;
        st_d.memAddr = {st_q.page, st_q.idx};
        st_d.idx = st_q.idx + 9'h1;
        if (st_q.idx == 9'h1ff) begin
          st_d.idx = 9'h0;
          st_d.acc = 8'h0;
          st_d.fsm = st_q.storing ? S_STORE : S_IDLE;
        end
      end

      // Only reached from an erase of the user page
      S_STORE: begin
        // Image: settings bytes, then their ones count as the last byte
        st_d.memWe = 1'b1;
        st_d.memWd = srcByte;
        st_d.memAddr = {`PAGE_USER, st_q.idx}; // see [R17] [R16]
        st_d.idx = st_q.idx + 9'h1;
        if (st_q.idx < 9'(`NCFG)) begin
          st_d.acc = st_q.acc + ones(srcByte); // see [R19] [R22]
        end else begin
          st_d.fsm = S_IDLE;
        end
      end

      // Two cycles per byte: address out, then registered data back
      S_LOAD: begin
        st_d.ph = 1'b1;
        if (st_q.ph) begin
          st_d.ph = 1'b0;
          st_d.idx = st_q.idx + 9'h1;
          st_d.memAddr = {st_q.page, st_d.idx};
          if (st_q.idx < 9'(`NCFG)) begin
            st_d.cfg[st_q.idx[2:0]] = memRd;
            st_d.acc = st_q.acc + ones(memRd); // see [R20] [R22]
          end else begin
            st_d.chk = st_q.acc; // see [R21]
            st_d.crcFault = memRd != st_q.acc; // see [R20]
            st_d.fsm = S_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
      st_q.fsm <= S_LOAD; // see [R13]
      st_q.memAddr <= {`PAGE_USER, 9'h0};
      st_q.page <= `PAGE_USER;
      st_q.pw <= `PW_FACTORY;
      st_q.unlocked <= 1'b0; // see [R8]
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state record
  assign wbRsp = st_q.rsp;
  assign cfgOut = st_q.cfg;
  assign crcFault = st_q.crcFault;
  assign unlocked = st_q.unlocked;

endmodule

// >>> hw/nvm_ctrl_params.svh
/*
  Constants of the settings memory controller: register offsets, command
  codes, status bit positions, reset values and timing counts.
  Assumes inclusion by its bare name from the package and the design files.
*/
`ifndef NVM_CTRL_PARAMS_SVH
`define NVM_CTRL_PARAMS_SVH

// Register byte offsets on the Wishbone slave
`define OFS_CMD 8'h00
`define OFS_WDATA 8'h04
`define OFS_RDATA 8'h08
`define OFS_STATUS 8'h0c
`define OFS_CHKSUM 8'h10
`define OFS_OFFSET 8'h14
`define OFS_CFG 8'h20

// Command codes carried in the low byte of the command register
`define CMD_PAGE_DATA 4'hb
`define CMD_RESTORE_DEFAULT 8'h12
`define CMD_STORE_USER 8'h15
`define CMD_RESTORE_USER 8'h16
`define CMD_ADDR_OFFSET 8'hd3
`define CMD_PAGE_ERASE 8'hd4
`define CMD_PASSWORD 8'hd5

// Status register bits
`define STAT_BUSY 0
`define STAT_CRC_FAULT 1
`define STAT_FAIL 2
`define STAT_UNLOCKED 4

// Memory geometry and settings image
`define PAGE_DEFAULT 4'h0
`define PAGE_USER 4'h1
`define PAGE_FIRST_FREE 4'h4
`define NCFG 8
`define MAX_BLOCK 9'h100
`define PW_FACTORY 8'hff
`define ERASED_BYTE 8'hff

// Timing: erase and store take at least this long
`define CLK_KHZ 100000
`define ERASE_MS 35
`define ERASE_CYC (`ERASE_MS * `CLK_KHZ)

`endif

// >>> hw/nvm_ctrl_pkg.sv
/*
  Types shared by the settings memory controller: bus carriers, controller
  states and the packed state record.
  Assumes nvm_ctrl_params.svh on the include path.
*/
`include "nvm_ctrl_params.svh"

package nvm_ctrl_pkg;

  typedef enum logic [2:0] {
    S_IDLE, S_PROG, S_MEMRD, S_ERASE, S_STORE, S_LOAD
  } fsm_e;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_s;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_s;

  typedef logic [`NCFG-1:0][7:0] cfg_t;

  typedef struct packed {
    fsm_e fsm;
    logic ph;
    logic unlocked;
    logic armed;
    logic [7:0] pw;
    logic crcFault;
    logic fail;
    logic storing;
    logic [7:0] chk;
    logic [7:0] acc;
    logic [3:0] page;
    logic [8:0] offset;
    logic [8:0] count;
    logic [8:0] idx;
    logic [21:0] timer;
    logic memWe;
    logic [12:0] memAddr;
    logic [7:0] memWd;
    wb_rsp_s rsp;
    cfg_t cfg;
  } st_s;

endpackage
